/* File: logic/hbp_top.sv */
// Purpose: four bidirectional strobed parallel units behind apb
// Assumes: pins asynchronous to i_clock, apb on i_clock
// Notes: port a runs bidirectional after config byte c0
`timescale 1ns/1ps
module hbp_top (
	input  wire                      i_clock,
	input  wire                      i_rst_n,
	input  hbp_pkg::hbp_apb_req_t    i_apb,
	output hbp_pkg::hbp_apb_rsp_t    o_apb,
	input  hbp_pkg::hbp_pin_in_t [3:0]  i_pins,
	output hbp_pkg::hbp_pin_out_t [3:0] o_pins
);
	import hbp_pkg::*;

	localparam logic [3:0] STATUS_IDX [NUM_UNITS] = '{
		FIRST_UNIT_STATUS_IDX,
		SECOND_UNIT_STATUS_IDX,
		THIRD_UNIT_STATUS_IDX,
		FOURTH_UNIT_STATUS_IDX
	};

	hbp_state_t st;
	hbp_state_t next_st;

	always_comb begin
		hbp_unit_t cur;
		hbp_unit_t nu;
		logic       mapped;
		logic       setup;
		logic       done;
		logic [3:0] idx;
		logic [1:0] rsel;
		logic [7:0] wbyte;
		logic [7:0] rbyte;
		logic       bidir;
		logic       bstrb;
		logic       b_in;
		logic       stb_fall;
		logic       ack_fall;
		logic       pc2_fall;
		logic       sel;
		logic       wr;
		logic       rd;
		logic       intr_b;
		logic       bflag;
		logic [2:0] lo3;
		logic       next_bidir;
		cur = '0;
		nu = '0;
		rbyte = '0;
		bidir = 1'b0;
		bstrb = 1'b0;
		b_in = 1'b0;
		stb_fall = 1'b0;
		ack_fall = 1'b0;
		pc2_fall = 1'b0;
		sel = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		intr_b = 1'b0;
		bflag = 1'b0;
		lo3 = '0;
		next_bidir = 1'b0;
		mapped = 1'b0;
		setup = 1'b0;
		done = 1'b0;
		idx = '0;
		rsel = '0;
		wbyte = '0;
		next_st = st;
		idx = i_apb.paddr[5:2];
		rsel = idx[1:0];
		wbyte = i_apb.pwdata[7:0];
		// only the aligned words of the first 64 bytes exist
		mapped = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr[7:6] == 2'h0);
		setup = i_apb.psel && !i_apb.penable;
		// effects happen only at the completing edge
		done = i_apb.psel && i_apb.penable && st.rsp.pready;
		next_st.rsp.pready = setup;
		next_st.rsp.pslverr = setup && !mapped;
		next_st.rsp.prdata = '0;

		for (int u = 0; u < NUM_UNITS; u++) begin
			cur = st.unit[u];
			nu = cur;
			// pins pass s1 and s2; only s2 and s3 feed logic
			nu.s1 = i_pins[u];
			nu.s2 = cur.s1;
			nu.s3 = cur.s2;

			bidir = cur.cfg[CFG_A_MODE +: 2] == A_MODE_BIDIR;
			bstrb = cur.cfg[CFG_B_MODE];
			b_in = cur.cfg[CFG_B_IN];
			stb_fall = cur.s3.incoming_strobe_n && !cur.s2.incoming_strobe_n;
			ack_fall = cur.s3.outgoing_acknowledge_n
				&& !cur.s2.outgoing_acknowledge_n;
			pc2_fall = cur.s3.ctl_lo[2] && !cur.s2.ctl_lo[2];
			sel = done && mapped && (idx[3:2] == 2'(u));
			wr = sel && i_apb.pwrite && i_apb.pstrb[0];
			rd = sel && !i_apb.pwrite;

			// acknowledge clears first so a same-cycle host write wins
			if (bidir && ack_fall) begin
				nu.obf_n = 1'b1;
			end
			if (wr && rsel == IDX_PORT_A) begin
				nu.pa_out = wbyte;
				if (bidir) begin
					nu.obf_n = 1'b0;
				end
			end
			// read clears first so a same-cycle strobe wins
			if (rd && rsel == IDX_PORT_A && bidir) begin
				nu.ibf = 1'b0;
			end
			if (bidir && stb_fall) begin
				nu.pa_in = cur.s2.pa;
				nu.ibf = 1'b1;
			end

			if (bstrb && pc2_fall && !b_in) begin
				nu.obf_b_n = 1'b1;
			end
			if (wr && rsel == IDX_PORT_B) begin
				nu.pb_out = wbyte;
				if (bstrb && !b_in) begin
					nu.obf_b_n = 1'b0;
				end
			end
			if (rd && rsel == IDX_PORT_B && bstrb && b_in) begin
				nu.ibf_b = 1'b0;
			end
			if (bstrb && pc2_fall && b_in) begin
				nu.pb_in = cur.s2.pb;
				nu.ibf_b = 1'b1;
			end

			if (wr && rsel == IDX_STATUS) begin
				nu.clo_out = wbyte[2:0];
			end

			if (wr && rsel == IDX_CONFIG) begin
				if (wbyte[CFG_MODE_SET]) begin
					// a mode change restarts every handshake
					nu.cfg = wbyte;
					nu.obf_n = OBF_N_RESET;
					nu.ibf = 1'b0;
					nu.out_irq_enable = 1'b0;
					nu.in_irq_enable = 1'b0;
					nu.obf_b_n = OBF_N_RESET;
					nu.ibf_b = 1'b0;
					nu.inte_b = 1'b0;
					nu.clo_out = '0;
				end else begin
					unique case (wbyte[BSR_SEL +: 3])
						LINE_OUT_EN: begin
							nu.out_irq_enable = wbyte[BSR_VAL];
						end
						LINE_IN_EN: begin
							nu.in_irq_enable = wbyte[BSR_VAL];
						end
						LINE_B_EN: begin
							if (bstrb) begin
								nu.inte_b = wbyte[BSR_VAL];
							end else begin
								nu.clo_out[2] = wbyte[BSR_VAL];
							end
						end
						3'h1: begin
							nu.clo_out[1] = wbyte[BSR_VAL];
						end
						3'h0: begin
							nu.clo_out[0] = wbyte[BSR_VAL];
						end
						default: begin
							nu.clo_out = nu.clo_out;
						end
					endcase
				end
			end

			// read path from the current state
			bflag = b_in ? cur.ibf_b : cur.obf_b_n;
			intr_b = cur.inte_b && bflag;
			if (bstrb) begin
				lo3 = {cur.inte_b, bflag, intr_b};
			end else if (cur.cfg[CFG_CLO_IN]) begin
				lo3 = cur.s2.ctl_lo;
			end else begin
				lo3 = cur.clo_out;
			end
			unique case (rsel)
				IDX_PORT_A: begin
					if (bidir) begin
						rbyte = cur.pa_in;
					end else if (cur.cfg[CFG_A_IN]) begin
						rbyte = cur.s2.pa;
					end else begin
						rbyte = cur.pa_out;
					end
				end
				IDX_PORT_B: begin
					if (bstrb && b_in) begin
						rbyte = cur.pb_in;
					end else if (b_in) begin
						rbyte = cur.s2.pb;
					end else begin
						rbyte = cur.pb_out;
					end
				end
				IDX_CONFIG: begin
					rbyte = cur.cfg;
				end
				IDX_STATUS: begin
					// handshake input levels are deliberately absent
					if (bidir) begin
						rbyte = {cur.obf_n, cur.out_irq_enable, cur.ibf,
							cur.in_irq_enable,
							cur.pins.primary_port_irq_request, lo3};
					end else begin
						rbyte = {5'h00, lo3};
					end
				end
			endcase
			if (setup && mapped && idx == STATUS_IDX[u]) begin
				next_st.rsp.prdata = {24'h000000, rbyte};
			end else if (setup && mapped && idx[3:2] == 2'(u)) begin
				next_st.rsp.prdata = {24'h000000, rbyte};
			end

			// pin drive, all registered
			// new mode decides, so entering bidir drives port a in its first cycle only while the acknowledge input is low
			next_bidir = nu.cfg[CFG_A_MODE +: 2] == A_MODE_BIDIR;
			nu.pins.pa = nu.pa_out;
			if (next_bidir) begin
				nu.pins.pa_oe = !cur.s2.outgoing_acknowledge_n;
			end else begin
				nu.pins.pa_oe = !nu.cfg[CFG_A_IN];
			end
			nu.pins.pb = nu.pb_out;
			nu.pins.pb_oe = !nu.cfg[CFG_B_IN];
			if (nu.cfg[CFG_B_MODE]) begin
				bflag = nu.cfg[CFG_B_IN] ? nu.ibf_b : nu.obf_b_n;
				nu.pins.ctl_lo = {1'b0, bflag, nu.inte_b && bflag};
				nu.pins.ctl_lo_oe = OE_B_STROBED;
			end else begin
				nu.pins.ctl_lo = nu.clo_out;
				nu.pins.ctl_lo_oe = {3{!nu.cfg[CFG_CLO_IN]}};
			end
			nu.pins.outgoing_byte_pending_n = nu.obf_n;
			nu.pins.incoming_byte_latched = nu.ibf;
			// enables pair with the flags as this port defines them
			nu.pins.primary_port_irq_request =
				next_bidir
				&& ((nu.out_irq_enable && nu.ibf)
				|| (nu.in_irq_enable && nu.obf_n));
			next_st.unit[u] = nu;
		end

		// synchronous reset overrides everything computed above
		if (!i_rst_n) begin
			next_st = '0;
			for (int u = 0; u < NUM_UNITS; u++) begin
				next_st.unit[u].cfg = CFG_RESET;
				next_st.unit[u].obf_n = OBF_N_RESET;
				next_st.unit[u].obf_b_n = OBF_N_RESET;
				next_st.unit[u].pins.outgoing_byte_pending_n = OBF_N_RESET;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		st <= next_st;
	end

	assign o_apb = st.rsp;

	for (genvar g = 0; g < NUM_UNITS; g++) begin : g_pins
		assign o_pins[g] = st.unit[g].pins;
	end
endmodule

/* File: logic/hbp_pkg.sv */
// Purpose: shared constants and carriers of the handshake port block
// Assumes: four interface units, 8-bit ports, 32-bit apb data
// Notes: register index = byte address / 4
package hbp_pkg;
	localparam int NUM_UNITS = 4;
	localparam logic [1:0] IDX_PORT_A = 2'h0;
	localparam logic [1:0] IDX_PORT_B = 2'h1;
	localparam logic [1:0] IDX_CONFIG = 2'h2;
	localparam logic [1:0] IDX_STATUS = 2'h3;
	localparam logic [3:0] FIRST_UNIT_STATUS_IDX  = 4'h3;
	localparam logic [3:0] SECOND_UNIT_STATUS_IDX = 4'h7;
	localparam logic [3:0] THIRD_UNIT_STATUS_IDX  = 4'hB;
	localparam logic [3:0] FOURTH_UNIT_STATUS_IDX = 4'hF;
	localparam logic [7:0] CFG_RESET  = 8'h9B;
	localparam logic [7:0] CFG_BIDIR  = 8'hC0;
	localparam int CFG_MODE_SET = 7;
	localparam int CFG_A_MODE   = 5;
	localparam int CFG_A_IN     = 4;
	localparam int CFG_B_MODE   = 2;
	localparam int CFG_B_IN     = 1;
	localparam int CFG_CLO_IN   = 0;
	localparam logic [1:0] A_MODE_BIDIR = 2'h2;
	localparam int BSR_SEL = 1;
	localparam int BSR_VAL = 0;
	localparam logic [2:0] LINE_OUT_EN = 3'h6;
	localparam logic [2:0] LINE_IN_EN  = 3'h4;
	localparam logic [2:0] LINE_B_EN   = 3'h2;
	localparam logic [2:0] OE_B_STROBED = 3'h3;
	localparam logic OBF_N_RESET = 1'b1;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} hbp_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} hbp_apb_rsp_t;

	typedef struct packed {
		logic [7:0] pa;
		logic [7:0] pb;
		logic [2:0] ctl_lo;
		logic       incoming_strobe_n;
		logic       outgoing_acknowledge_n;
	} hbp_pin_in_t;

	typedef struct packed {
		logic [7:0] pa;
		logic       pa_oe;
		logic [7:0] pb;
		logic       pb_oe;
		logic [2:0] ctl_lo;
		logic [2:0] ctl_lo_oe;
		logic       outgoing_byte_pending_n;
		logic       incoming_byte_latched;
		logic       primary_port_irq_request;
	} hbp_pin_out_t;

	typedef struct packed {
		logic [7:0]   cfg;
		logic [7:0]   pa_out;
		logic [7:0]   pa_in;
		logic         obf_n;
		logic         ibf;
		logic         out_irq_enable;
		logic         in_irq_enable;
		logic [7:0]   pb_out;
		logic [7:0]   pb_in;
		logic         obf_b_n;
		logic         ibf_b;
		logic         inte_b;
		logic [2:0]   clo_out;
		hbp_pin_in_t  s1;
		hbp_pin_in_t  s2;
		hbp_pin_in_t  s3;
		hbp_pin_out_t pins;
	} hbp_unit_t;

	typedef struct packed {
		hbp_unit_t [NUM_UNITS-1:0] unit;
		hbp_apb_rsp_t              rsp;
	} hbp_state_t;
endpackage

/* File: bench/hbp_top_checker.sv */
// Purpose: port checks of unit 0
// Assumes: unit 0 faces the external model
// Notes: mode is tracked from apb writes
`timescale 1ns/1ps
module hbp_top_checker import hbp_pkg::*; (
	input wire                        i_clock,
	input wire                        i_rst_n,
	input hbp_pkg::hbp_apb_req_t      i_apb,
	input hbp_pkg::hbp_apb_rsp_t      o_apb,
	input hbp_pkg::hbp_pin_in_t [3:0] i_pins,
	input hbp_pkg::hbp_pin_out_t [3:0] o_pins
);
	logic         bidir;
	logic         acc;
	logic         kill;
	hbp_pin_out_t p;
	hbp_pin_in_t  q;
	assign acc = i_apb.psel & i_apb.penable & o_apb.pready;
	assign kill = acc & (i_apb.paddr == 8'h00 ^ i_apb.pwrite) &
		(i_apb.paddr == 8'h00 | i_apb.paddr == 8'h08);
	assign p = o_pins[0];
	assign q = i_pins[0];
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			bidir <= 1'b0;
		end else if (acc & i_apb.pwrite & i_apb.pstrb[0] & i_apb.paddr == 8'h08 &
			i_apb.pwdata[7]) begin
			bidir <= i_apb.pwdata[6:5] == 2'h2;
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	AST_ERR: assert property (acc & (i_apb.paddr[1:0] != 2'h0) |-> o_apb.pslverr)
		else $error("no error on unmapped address");
	AST_WIDTH: assert property (o_apb.pready |-> o_apb.prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_OBF: assert property (bidir & acc & i_apb.pwrite & i_apb.paddr == 8'h00
		|-> ##[1:2] !p.outgoing_byte_pending_n) else $error("pending flag not set");
	AST_ACK: assert property (bidir & $fell(q.outgoing_acknowledge_n)
		|-> ##[1:6] p.outgoing_byte_pending_n) else $error("ack did not release");
	AST_OE: assert property ((bidir & q.outgoing_acknowledge_n)[*5] |-> !p.pa_oe)
		else $error("port driven without ack");
	AST_STB: assert property (bidir & $fell(q.incoming_strobe_n)
		|-> ##[1:6] p.incoming_byte_latched) else $error("strobe not latched");
	AST_HOLD: assert property (bidir & p.incoming_byte_latched & !kill & !$past(kill)
		|=> p.incoming_byte_latched) else $error("input flag lost");
	AST_IRQ: assert property ((!p.incoming_byte_latched & !p.outgoing_byte_pending_n)[*2]
		|-> !p.primary_port_irq_request) else $error("request without cause");
	AST_OE_MODE: assert property ($rose(bidir) & q.outgoing_acknowledge_n
		& $past(q.outgoing_acknowledge_n) & $past(q.outgoing_acknowledge_n, 2)
		& $past(q.outgoing_acknowledge_n, 3) |-> !p.pa_oe)
		else $error("port driven on mode entry");
	cover property (bidir & kill & p.incoming_byte_latched);
	cover property (p.primary_port_irq_request);
	cover property (bidir & $fell(q.outgoing_acknowledge_n));
endmodule

/* File: bench/hbp_ext_dev.sv */
// Purpose: external strobe/ack device on unit 0
// Assumes: released lines float high
// Notes: tasks are called by the bench
`timescale 1ns/1ps
module hbp_ext_dev import hbp_pkg::*; (
	input wire                    i_clock,
	input hbp_pkg::hbp_pin_out_t  i_dut,
	output hbp_pkg::hbp_pin_in_t  o_pins
);
	logic [7:0] drv;
	logic       den;
	logic       stb_n;
	logic       ack_n;
	initial begin
		drv = 8'h00;
		den = 1'b0;
		stb_n = 1'b1;
		ack_n = 1'b1;
	end
	// pull-ups win on every released line
	always_comb begin
		o_pins.pa = i_dut.pa_oe ? i_dut.pa : (den ? drv : 8'hFF);
		o_pins.pb = i_dut.pb_oe ? i_dut.pb : 8'hFF;
		o_pins.ctl_lo = (i_dut.ctl_lo & i_dut.ctl_lo_oe) | ~i_dut.ctl_lo_oe;
		o_pins.incoming_strobe_n = stb_n;
		o_pins.outgoing_acknowledge_n = ack_n;
	end
	task automatic send(input logic [7:0] v);
		@(posedge i_clock);
		drv <= v;
		den <= 1'b1;
		repeat (3) @(posedge i_clock);
		stb_n <= 1'b0;
		repeat (4) @(posedge i_clock);
		stb_n <= 1'b1;
		repeat (3) @(posedge i_clock);
		den <= 1'b0;
	endtask
	task automatic take(input int dly, output logic [7:0] v);
		repeat (dly) @(posedge i_clock);
		ack_n <= 1'b0;
		repeat (8) @(posedge i_clock);
		v = o_pins.pa;
		ack_n <= 1'b1;
	endtask
endmodule

/* File: bench/hbp_top_tb.sv */
// Purpose: bench of the handshake port block
// Assumes: units 1 to 3 see pulled-up pins
// Notes: unit 0 exchanges bytes with the model
`timescale 1ns/1ps
module hbp_top_tb import hbp_pkg::*;;
	logic              i_clock;
	logic              i_rst_n;
	hbp_apb_req_t      i_apb;
	hbp_apb_rsp_t      o_apb;
	hbp_pin_in_t [3:0] i_pins;
	hbp_pin_out_t [3:0] o_pins;
	hbp_pin_in_t       ext;
	int                err_total;
	int                checks;
	logic [32:0]       q;
	logic [7:0]        b;
	assign i_pins = {{3{21'h1FFFFF}}, ext};
	hbp_top i_hbp_top (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_apb(i_apb),
		.o_apb(o_apb), .i_pins(i_pins), .o_pins(o_pins));
	hbp_ext_dev i_hbp_ext_dev (.i_clock(i_clock), .i_dut(o_pins[0]), .o_pins(ext));
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	task automatic complete_run();
		if (err_total == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge i_clock);
		i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
			pwdata: {24'h0, d}, pstrb: 4'hF};
		@(posedge i_clock);
		i_apb.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_apb.pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			complete_run();
		end
		q = {o_apb.pslverr, o_apb.prdata};
		i_apb.psel <= 1'b0;
		i_apb.penable <= 1'b0;
	endtask
	task automatic sts(input logic [7:0] a, input logic [4:0] e);
		apb(1'b0, a, 8'h00);
		cmp8({3'h0, q[7:3]}, {3'h0, e});
	endtask
	task automatic poll(input int k);
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h0C, 8'h00);
			n++;
		end while (q[k] !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			complete_run();
		end
	endtask
	task automatic t_out();
		apb(1'b0, 8'h08, 8'h00);
		cmp8(q[7:0], CFG_RESET);
		sts(8'h0C, 5'h00);
		apb(1'b1, 8'h08, CFG_BIDIR);
		sts(8'h0C, 5'h10);
		apb(1'b1, 8'h08, 8'h0D);
		sts(8'h0C, 5'h18);
		apb(1'b1, 8'h00, 8'hA5);
		sts(8'h0C, 5'h08);
		i_hbp_ext_dev.take(3, b);
		cmp8(b, 8'hA5);
		poll(7);
	endtask
	task automatic t_in();
		i_hbp_ext_dev.send(8'h3C);
		poll(5);
		sts(8'h0C, 5'h1D);
		cmp8({7'h0, o_pins[0].primary_port_irq_request}, 8'h01);
		apb(1'b0, 8'h00, 8'h00);
		cmp8(q[7:0], 8'h3C);
		sts(8'h0C, 5'h18);
	endtask
	task automatic t_irq_out();
		apb(1'b1, 8'h08, 8'h09);
		apb(1'b1, 8'h08, 8'h0C);
		sts(8'h0C, 5'h13);
		apb(1'b1, 8'h00, 8'h5A);
		sts(8'h0C, 5'h02);
		i_hbp_ext_dev.take(20, b);
		cmp8(b, 8'h5A);
		poll(7);
		cmp8({7'h0, o_pins[0].primary_port_irq_request}, 8'h01);
	endtask
	task automatic t_map();
		apb(1'b0, 8'h01, 8'h00);
		cmp8({7'h0, q[32]}, 8'h01);
		apb(1'b0, 8'h40, 8'h00);
		cmp8({7'h0, q[32]}, 8'h01);
		sts(8'h1C, 5'h00);
		apb(1'b1, 8'h18, CFG_BIDIR);
		sts(8'h1C, 5'h10);
	endtask
	task automatic t_lines();
		apb(1'b1, 8'h0C, 8'h04);
		apb(1'b1, 8'h08, 8'h03);
		apb(1'b0, 8'h0C, 8'h00);
		cmp8({5'h0, q[2:0]}, 8'h06);
		cmp8({5'h0, o_pins[0].ctl_lo}, 8'h06);
		cmp8({5'h0, o_pins[0].ctl_lo_oe}, 8'h07);
		apb(1'b1, 8'h04, 8'h77);
		@(posedge i_clock);
		cmp8(o_pins[0].pb, 8'h77);
		cmp8({7'h0, o_pins[0].pb_oe}, 8'h01);
		apb(1'b1, 8'h18, 8'hC4);
		apb(1'b1, 8'h18, 8'h05);
		apb(1'b0, 8'h1C, 8'h00);
		cmp8({5'h0, q[2:0]}, 8'h07);
		cmp8({5'h0, o_pins[1].ctl_lo & o_pins[1].ctl_lo_oe}, 8'h03);
	endtask
	initial begin
		i_apb = '0;
		i_rst_n = 1'b0;
		err_total = 0;
		checks = 0;
		repeat (16) @(posedge i_clock);
		i_rst_n <= 1'b1;
		t_out();
		t_in();
		t_irq_out();
		t_map();
		t_lines();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge i_clock);
		err_total++;
		complete_run();
	end
endmodule
bind hbp_top hbp_top_checker i_hbp_top_checker (.i_clock(i_clock), .i_rst_n(i_rst_n),
	.i_apb(i_apb), .o_apb(o_apb), .i_pins(i_pins), .o_pins(o_pins));
